//--- core/ch_demand.sv
// Central-heat demand with on/off hysteresis and stepped thresholds.
// Assumes temperatures and settings are synchronous and stable between changes.
`timescale 1ns/1ps
`include "ch_demand_map.svh"
module ch_demand #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                        i_clock,
  input  wire logic                        i_rstn,
  input  wire ch_demand_pkg::demand_src_t  i_demand_source,
  input  wire logic                        i_use_header,
  input  wire logic [7:0]                  i_outlet_temp,
  input  wire logic [7:0]                  i_header_temp,
  input  wire logic [7:0]                  i_setpoint,
  input  wire logic                        i_time_of_day_input,
  input  wire logic                        i_outdoor_reset,
  input  wire logic [7:0]                  i_outdoor_reset_setpoint,
  input  wire logic [7:0]                  i_on_hyst,
  input  wire logic [7:0]                  i_off_hyst,
  input  wire logic [7:0]                  i_step_time,
  input  wire logic                        i_stat,
  input  wire logic                        i_load_control_input,
  input  wire logic                        i_remote_msg,
  input  wire logic                        i_remote_on,
  output logic                             o_burner_demand,
  output logic                             o_pump_demand,
  output logic                             o_setpoint_defined,
  output logic [7:0]                       o_rate_controller_setpoint,
  output logic [7:0]                       o_rate_controller_temp
);
  import ch_demand_pkg::*;
  localparam int unsigned SEC_CYCLES = TICK_CYCLES;

  // Overview of the demand path, as the next engineer will want it:
  // - One temperature is chosen, outlet or header, and that same value feeds
  //   both the demand comparison and the rate controller port.
  // - The setpoint is either the plain setpoint or the outdoor reset result,
  //   which is worked out upstream. The time-of-day input is accepted but not
  //   used here: the time-of-day setpoint is chosen before this block.
  // - A hysteresis value of all ones means "not defined". Then the block
  //   never asks for the burner and flags the setpoint as undefined.
  // - Sensor demand turns on strictly below the on threshold and off strictly
  //   above the off threshold. Between the two, the last state holds.
  // - The external source gates burner demand in every mode except sensor
  //   only. Losing it drops the burner at once, whatever the temperature.
  // - Pump demand follows the external source. In sensor-only mode it
  //   follows the burner instead.
  // - After a turn-on the off threshold starts high and comes down in steps.
  //   After a turn-off the on threshold starts low and comes up in steps.
  //   This leaves the rate controller room to overshoot without short cycles.
  // - The step timer restarts on every burner transition. Its count
  //   saturates, so a long run settles on the plain thresholds.
  // - A step time of zero holds the count at zero and skips all widening.
  // - The on threshold may underflow below zero degrees. That case is
  //   treated as "never on" rather than wrapping to a huge value.
  // - A remote message older than the timeout counts as "thermostat off".
  //   The age counter is restarted by every message, on or off.
  // Limitations:
  // - Temperatures are whole degrees, unsigned, 8 bits. Negative water
  //   temperatures cannot be shown.
  // - The seconds tick is a plain cycle count. A clock that is not exactly
  //   TICK_CYCLES per second stretches every step by the same factor.
  // - Settings are assumed steady between changes. A change in mid-step
  //   simply takes effect on the next edge.

  step_link_if link ();
  burner_state_t state;
  logic [7:0]  temp;
  logic [7:0]  setpoint;
  logic        defined;
  logic [9:0]  on_thr;
  logic [9:0]  off_thr;
  logic [7:0]  boost;
  logic [8:0]  on_steps_need;
  logic [9:0]  on_raise;
  logic        ext_active;
  logic        sensor_want;
  logic        sensor_drop;
  logic [31:0] msg_cycles;
  logic [7:0]  msg_secs;
  logic        remote_state;
  logic        remote_fresh;
  logic        next_burner;

  step_timer #(.TICK_CYCLES(SEC_CYCLES)) u_step_timer (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .link    (link.timer)
  );

  // Sensor and setpoint selection; outdoor curve is computed elsewhere
  assign temp     = i_use_header ? i_header_temp : i_outlet_temp;
  assign setpoint = i_outdoor_reset ? i_outdoor_reset_setpoint : i_setpoint;
  assign defined  = (i_on_hyst != `HYST_NONE) && (i_off_hyst != `HYST_NONE);

  // Off threshold boost schedule after turn-on
  always_comb begin
    case (link.steps)
      8'h0: boost = `OFF_BOOST_0;
      8'h1: boost = `OFF_BOOST_1;
      8'h2: boost = `OFF_BOOST_2;
      8'h3: boost = `OFF_BOOST_3;
      8'h4: boost = `OFF_BOOST_4;
      default: boost = 8'h0;
    endcase
  end

  // Thresholds; zero step time means no widening at all
  assign on_steps_need = {1'b0, i_on_hyst} >> 1;
  assign on_raise = ({2'b00, link.steps} >= {1'b0, on_steps_need}) ? {2'b00, i_on_hyst}
                  : {1'b0, link.steps, 1'b0};
  always_comb begin
    off_thr = {2'b00, setpoint} + {2'b00, i_off_hyst};
    on_thr  = {2'b00, setpoint} - {2'b00, i_on_hyst};
    if (i_step_time != 8'h0 && state == burner_on) begin
      off_thr = off_thr + {2'b00, boost};
    end
    if (i_step_time != 8'h0 && state == burner_off) begin
      on_thr = {2'b00, setpoint} - {1'b0, i_on_hyst, 1'b0} + on_raise;
    end
  end

  // Unsigned 10-bit comparisons; underflowed on threshold (bit 9 set) never asserts
  assign sensor_want = defined && !on_thr[9] && ({2'b00, temp} < on_thr);
  assign sensor_drop = !defined || ({2'b00, temp} > off_thr);

  // Remote thermostat message age in seconds
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      msg_cycles   <= 32'h0;
      msg_secs     <= 8'h0;
      remote_state <= 1'b0;
      remote_fresh <= 1'b0;
    end else if (i_remote_msg) begin
      msg_cycles   <= 32'h0;
      msg_secs     <= 8'h0;
      remote_state <= i_remote_on;
      remote_fresh <= 1'b1;
    end else if (msg_cycles == SEC_CYCLES - 1) begin
      msg_cycles <= 32'h0;
      if (msg_secs == 8'(`REMOTE_TIMEOUT_S - 1)) begin
        remote_fresh <= 1'b0;
      end else begin
        msg_secs <= msg_secs + 8'h1;
      end
    end else begin
      msg_cycles <= msg_cycles + 32'h1;
    end
  end

  // External demand per source setting
  always_comb begin
    case (i_demand_source)
      src_stat_sensor:   ext_active = i_stat;
      src_remote_sensor: ext_active = remote_state && remote_fresh;
      src_lci_sensor:    ext_active = i_load_control_input;
      src_sensor_only:   ext_active = 1'b1;
      default:           ext_active = 1'b0;
    endcase
  end

  // Burner demand with hysteresis, gated by external demand
  always_comb begin
    next_burner = o_burner_demand;
    if (!ext_active) begin
      next_burner = 1'b0;
    end else if (!o_burner_demand && sensor_want) begin
      next_burner = 1'b1;
    end else if (o_burner_demand && sensor_drop) begin
      next_burner = 1'b0;
    end
  end

  // Registered burner demand
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_burner_demand <= 1'b0;
    end else begin
      o_burner_demand <= next_burner;
    end
  end

  // Burner state, kept apart so threshold widening has its own record
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= burner_off;
    end else begin
      case (state)
        burner_off: if (next_burner) state <= burner_on;
        burner_on:  if (!next_burner) state <= burner_off;
        default:    state <= burner_off;
      endcase
    end
  end
  assign link.restart   = next_burner != o_burner_demand;
  assign link.step_time = i_step_time;

  // Pump demand, registered in step with the burner demand
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pump_demand <= 1'b0;
    end else begin
      o_pump_demand <= (i_demand_source == src_sensor_only) ? next_burner : ext_active;
    end
  end

  // Rate controller inputs, one cycle behind the selection
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_setpoint_defined         <= 1'b0;
      o_rate_controller_setpoint <= 8'h0;
      o_rate_controller_temp     <= 8'h0;
    end else begin
      o_setpoint_defined         <= defined;
      o_rate_controller_setpoint <= setpoint;
      o_rate_controller_temp     <= temp;
    end
  end
endmodule

//--- core/ch_demand_map.svh
// Constants for the central-heat demand block: field widths, offsets, timing.
// Assumes temperatures are unsigned whole degrees F, 8 bits wide.
// Function
// - Sensor demand on below setpoint minus on-hysteresis
// - Hold demand until above off threshold or source off
// - Burner demand always needs sensor demand
// - Sensor only: ignore inputs, pump follows burner
// - Wired stat gates burner, makes pump demand
// - Remote stat message gates, timeout removes demand
// - Load control input gates burner, makes pump
// - Selected outlet or header sensor used throughout
// - Setpoint used as-is without outdoor reset
// - None hysteresis means no setpoint defined
// - Thresholds adjusted at burner on/off transitions
// - Turn-on raises off threshold by 18 F
// - Step time in seconds; zero disables stepping
// - Compared temperature and setpoint fed to rate controller
// - Off offset steps 8,6,4,2 then none
// - Turn-off: on threshold at setpoint minus twice hysteresis, +2/step
// - On stepping stops at hysteresis/2 steps
`ifndef CH_DEMAND_MAP_SVH
`define CH_DEMAND_MAP_SVH
`define TEMP_W            8
`define STEP_W            8
`define HYST_NONE         8'hff
`define OFF_BOOST_0       8'h12
`define OFF_BOOST_1       8'h08
`define OFF_BOOST_2       8'h06
`define OFF_BOOST_3       8'h04
`define OFF_BOOST_4       8'h02
`define ON_STEP_DEG       8'h02
`define CLOCK_HZ          50000000
`define TICK_CYCLES       (`CLOCK_HZ)
`define REMOTE_TIMEOUT_S  180
`endif

//--- core/ch_demand_pkg.sv
// Types for the central-heat demand block.
// Assumes the constants header is included where numbers are needed.
package ch_demand_pkg;
  typedef enum logic [1:0] {
    src_stat_sensor   = 2'h0,
    src_remote_sensor = 2'h1,
    src_lci_sensor    = 2'h2,
    src_sensor_only   = 2'h3
  } demand_src_t;
  typedef enum logic [1:0] {
    burner_off = 2'h1,
    burner_on  = 2'h2
  } burner_state_t;
endpackage

//--- core/step_link_if.sv
// Interface carrying step timer control and count between the two modules.
// Assumes one clock domain.
`timescale 1ns/1ps
interface step_link_if;
  logic       restart;
  logic [7:0] step_time;
  logic [7:0] steps;
  modport timer (input restart, input step_time, output steps);
  modport user  (output restart, output step_time, input steps);
endinterface

//--- core/step_timer.sv
// Seconds tick and step interval counter for threshold stepping.
// Assumes the restart pulse marks each burner transition.
`timescale 1ns/1ps
`include "ch_demand_map.svh"
module step_timer #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_rstn,
  step_link_if.timer link
);
  logic [31:0] tick_count;
  logic        tick;
  logic [7:0]  sec_count;
  logic [7:0]  step_count;

  // One-second tick from the system clock
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_count <= 32'h0;
    end else if (link.restart || tick_count == TICK_CYCLES - 1) begin
      tick_count <= 32'h0;
    end else begin
      tick_count <= tick_count + 32'h1;
    end
  end
  assign tick = (tick_count == TICK_CYCLES - 1) && !link.restart;

  // Seconds within step and saturating step count; zero step time holds at zero
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sec_count  <= 8'h0;
      step_count <= 8'h0;
    end else if (link.restart || link.step_time == 8'h0) begin
      sec_count  <= 8'h0;
      step_count <= 8'h0;
    end else if (tick) begin
      if (sec_count + 8'h1 >= link.step_time) begin
        sec_count <= 8'h0;
        if (step_count != 8'hff) begin
          step_count <= step_count + 8'h1;
        end
      end else begin
        sec_count <= sec_count + 8'h1;
      end
    end
  end
  assign link.steps = step_count;
endmodule

//--- verif/ch_demand_chk.sv
// Assertions on the central-heat demand ports.
// Assumes one clock domain and bind onto every ch_demand instance.
`timescale 1ns/1ps
`include "ch_demand_map.svh"
module ch_demand_chk import ch_demand_pkg::*; #(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic        i_clock,
  input wire logic        i_rstn,
  input wire demand_src_t i_demand_source,
  input wire logic        i_use_header,
  input wire logic [7:0]  i_outlet_temp,
  input wire logic [7:0]  i_header_temp,
  input wire logic [7:0]  i_setpoint,
  input wire logic        i_outdoor_reset,
  input wire logic [7:0]  i_outdoor_reset_setpoint,
  input wire logic [7:0]  i_on_hyst,
  input wire logic [7:0]  i_off_hyst,
  input wire logic [7:0]  i_step_time,
  input wire logic        i_stat,
  input wire logic        i_load_control_input,
  input wire logic        o_burner_demand,
  input wire logic        o_pump_demand,
  input wire logic        o_setpoint_defined,
  input wire logic [7:0]  o_rate_controller_setpoint,
  input wire logic [7:0]  o_rate_controller_temp
);
  logic [7:0] t;
  logic [7:0] s;
  logic       ok;
  logic       fix;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // Selected sensor and setpoint; fix means defined hysteresis, sensor-only with stepping off
  assign t   = i_use_header ? i_header_temp : i_outlet_temp;
  assign s   = i_outdoor_reset ? i_outdoor_reset_setpoint : i_setpoint;
  assign ok  = (i_on_hyst != `HYST_NONE) && (i_off_hyst != `HYST_NONE);
  assign fix = ok && (i_step_time == 8'h00) && (i_demand_source == src_sensor_only);
  rc_temp_a: assert property ($past(i_rstn) |-> o_rate_controller_temp == $past(t))
    else $error("rate controller temperature wrong");
  rc_setpoint_a: assert property ($past(i_rstn) |-> o_rate_controller_setpoint == $past(s))
    else $error("rate controller setpoint wrong");
  setpoint_defined_a: assert property ($past(i_rstn) |-> o_setpoint_defined == $past(ok))
    else $error("setpoint defined flag wrong");
  none_blocks_a: assert property (!ok |=> !o_burner_demand)
    else $error("burner demand with undefined hysteresis");
  stat_gate_a: assert property (i_demand_source == src_stat_sensor && !i_stat |=> !o_burner_demand && !o_pump_demand)
    else $error("demand with thermostat off");
  lci_gate_a: assert property (i_demand_source == src_lci_sensor && !i_load_control_input |=> !o_burner_demand && !o_pump_demand)
    else $error("demand with load control off");
  burner_pump_a: assert property (o_burner_demand && $stable(i_demand_source) && i_demand_source != src_sensor_only |-> o_pump_demand)
    else $error("burner demand without pump demand");
  sensor_on_a: assert property (fix && s >= i_on_hyst && t < s - i_on_hyst |=> o_burner_demand)
    else $error("no demand below on threshold");
  sensor_off_a: assert property (fix && {1'b0, t} > {1'b0, s} + i_off_hyst |=> !o_burner_demand)
    else $error("demand above off threshold");
  hold_band_a: assert property (o_burner_demand && fix && {1'b0, t} <= {1'b0, s} + i_off_hyst |=> o_burner_demand)
    else $error("demand dropped inside band");
endmodule
bind ch_demand ch_demand_chk #(.TICK_CYCLES(TICK_CYCLES)) i_ch_demand_chk (.*);

//--- verif/remote_stat_model.sv
// Remote thermostat sender: one-cycle message pulses toward the block.
// Assumes the bench requests a message by holding i_send for one cycle.
`timescale 1ns/1ps
module remote_stat_model (
  input  wire logic i_clock,
  input  wire logic i_send,
  input  wire logic i_on,
  output logic      o_msg,
  output logic      o_on
);
  // Data is valid only with the pulse; it toggles otherwise so stale data is never trusted
  always_ff @(posedge i_clock) begin
    o_msg <= i_send;
    o_on  <= i_send ? i_on : ~o_on;
  end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the central-heat demand block.
// Assumes a seconds tick shortened to 10 clocks, so a step of 1 s is 10 cycles.
`timescale 1ns/1ps
module testbench;
  import ch_demand_pkg::*;
  logic        clk, rstn = 0, hdr = 0, time_of_day_input = 0, outdoor_reset = 0, stat = 0, load_control_input = 0, send = 0, son = 0, msg, mon, pb, pp, pd;
  logic [7:0]  ot = 8'h64, ht = 8'h64, sp = 8'h64, osp = 8'h50, onh = 8'h04, offh = 8'h04, st = 8'h00, rt, rs;
  demand_src_t src = src_sensor_only;
  logic [9:0]  q[$];
  logic [9:0]  e;
  int          fail_count = 0, cmp_count = 0;
  event        look;
  ch_demand #(.TICK_CYCLES(10)) i_ch_demand (.i_clock(clk), .i_rstn(rstn), .i_demand_source(src), .i_use_header(hdr),
    .i_outlet_temp(ot), .i_header_temp(ht), .i_setpoint(sp), .i_time_of_day_input(time_of_day_input), .i_outdoor_reset(outdoor_reset),
    .i_outdoor_reset_setpoint(osp), .i_on_hyst(onh), .i_off_hyst(offh), .i_step_time(st), .i_stat(stat),
    .i_load_control_input(load_control_input), .i_remote_msg(msg), .i_remote_on(mon), .o_burner_demand(pb), .o_pump_demand(pp),
    .o_setpoint_defined(pd), .o_rate_controller_setpoint(rs), .o_rate_controller_temp(rt));
  remote_stat_model i_remote_stat_model (.i_clock(clk), .i_send(send), .i_on(son), .o_msg(msg), .o_on(mon));
  // 50 MHz clock
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic note(input logic [1:0] k, input logic [7:0] v);
    q.push_back({k, v});
    ->look;
  endtask
  task automatic dem(input logic d, input logic b, input logic p);
    note(2'h0, {5'h0, d, b, p});
  endtask
  // Remote messages go through the partner as a single pulse
  task automatic gate(input int m, input logic v);
    case (m)
      0: stat = v;
      1: begin
        son = v;
        send = 1;
        cyc(1);
        send = 0;
      end
      default: load_control_input = v;
    endcase
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Drain every note: several may be posted in one time step
  always @(look) begin
    while (q.size() > 0) begin
      e = q.pop_front();
      if (e[9:8] == 2'h0) check({5'h0, pd, pb, pp}, e[7:0]);
      else if (e[9:8] == 2'h1) check(rt, e[7:0]);
      else check(rs, e[7:0]);
    end
  end
  // Hang guard, far beyond the few thousand cycles the tests need
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  initial begin
    void'($urandom(32'hc44f9cd5));
    cyc(3);
    rstn = 1;
    cyc(30);
    ot = 8'h5f;
    cyc(2);
    dem(1, 1, 1);
    ot = 8'h67;
    cyc(2);
    dem(1, 1, 1);
    ot = 8'h69;
    cyc(2);
    dem(1, 0, 0);
    $display("sensor only done");
    for (int m = 0; m < 3; m++) begin
      src = demand_src_t'(m);
      ot = 8'h5a;
      gate(m, 0);
      cyc(3);
      dem(1, 0, 0);
      gate(m, 1);
      cyc(3);
      dem(1, 1, 1);
      ot = 8'h6e;
      cyc(3);
      dem(1, 0, 1);
      gate(m, 0);
      cyc(3);
      dem(1, 0, 0);
    end
    ot = 8'h5a;
    src = src_remote_sensor;
    gate(1, 1);
    cyc(1700);
    dem(1, 1, 1);
    cyc(200);
    dem(1, 0, 0);
    $display("sources done");
    src = src_sensor_only;
    onh = 8'hff;
    cyc(3);
    dem(0, 0, 0);
    onh = 8'h04;
    offh = 8'hff;
    cyc(3);
    dem(0, 0, 0);
    offh = 8'h04;
    for (int i = 0; i < 4; i++) begin
      ot = 8'($urandom);
      ht = 8'($urandom);
      osp = 8'($urandom);
      time_of_day_input = 1'($urandom);
      hdr = i[0];
      outdoor_reset = i[1];
      cyc(2);
      note(2'h1, hdr ? ht : ot);
      note(2'h2, outdoor_reset ? osp : sp);
    end
    $display("selection done");
    hdr = 0;
    outdoor_reset = 0;
    st = 8'h01;
    ot = 8'h5a;
    cyc(60);
    ot = 8'h6a;
    cyc(1);
    ot = 8'h5f;
    cyc(3);
    dem(1, 0, 0);
    ot = 8'h60;
    cyc(60);
    dem(1, 0, 0);
    ot = 8'h5f;
    cyc(3);
    dem(1, 1, 1);
    ot = 8'h78;
    cyc(3);
    dem(1, 1, 1);
    cyc(25);
    dem(1, 0, 0);
    $display("stepping done");
    final_report();
  end
endmodule
